// *** src/epc_pkg.sv ***
// Package: register map, field positions and types of the EPROM program control block
package epc_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [31:0] EPC_CTRL_ADDR = 32'h0000_0007 << 2; // Index 7, one word per register
   localparam logic [31:0] EPC_STAT_ADDR = 32'h0000_0020;      // Status word
   localparam logic [31:0] EPC_GRP_ADDR = 32'h0000_0024;       // Latched group address
   localparam logic [31:0] EPC_WIN_BASE = 32'h0002_0000;       // Array window base, above all word index bits
   localparam logic [31:0] EPC_WIN_MASK = 32'hFFFE_0000;       // Array window decode mask
   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int EPC_LAT_BIT = 5;
   localparam int EPC_PGM_BIT = 4;
   localparam logic [7:0] EPC_CTRL_RESET = 8'h00;
   localparam logic [7:0] EPC_ERASED = 8'h00;   // Erased byte value
   localparam logic [7:0] EPC_GARBLE = 8'hFF;   // Read value while latched
   localparam int EPC_GRP_BYTES = 16;
   localparam int EPC_LSB_W = 4;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      EPC_READ = 2'b00,
      EPC_READY = 2'b01,
      EPC_PROG = 2'b11
   } epc_state_e;
   typedef struct packed {
      logic valid;
      logic [EPC_LSB_W-1:0] idx;
      logic [7:0] data;
   } epc_wr_s;
   typedef struct packed {
      logic fetch;       // Instruction fetch from array
      logic vector;      // Vector load from array
      logic boot;        // Fetch from bootstrap ROM
   } epc_cpu_s;
endpackage

// *** src/epc_slot.sv ***
// One latch slot of the program group: holds a byte and its valid flag
`timescale 1ns/1ps
module epc_slot (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic clr,
   input wire logic wr,
   input wire logic [7:0] din,
   output logic vld,
   output logic [7:0] dout
);
   logic vld_q, vld_d;
   logic [7:0] dat_q, dat_d;
   // Next values: capture on write, drop on clear
   always_comb begin
      vld_d = vld_q;
      dat_d = dat_q;
      if (clr) begin
         vld_d = 1'b0;
      end else if (wr) begin
         vld_d = 1'b1;
         dat_d = din;
      end
   end
   // Registers
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         vld_q <= 1'b0;
         dat_q <= 8'h00;
      end else begin
         vld_q <= vld_d;
         dat_q <= dat_d;
      end
   end
   assign vld = vld_q;
   assign dout = dat_q;
endmodule

// *** src/epc_top.sv ***
// EPROM program control: control register, group latches and array model behind AHB-Lite
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - Latch clear: array reads and fetches return stored bytes.
// - Program enable is held zero whenever latch enable is zero.
// - Latch set: array reads return a value unrelated to memory.
// - Latch set: vector loads from the array are flagged invalid.
// - Latch set: bootstrap ROM fetches are flagged invalid.
// - Stop entry returns the array to read mode, clearing both bits.
// - Erased bytes read zero; programming only sets bits.
// - Repeat programming of a byte only accumulates one bits.
// - Up to sixteen bytes per group, sharing all upper address bits.
// - Latch set, program clear: array writes fill group latches.
// - Stop, power-on and external reset clear latch and program bits.
// - Program enable sets only if latched and a byte was written.
// - Writing zero to program enable has no effect.
// - Bits encode read, ready-to-latch and programming states.
module epc_top #(
   parameter int ADDR_W = 15,
   parameter int DEPTH = 32768
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   input wire logic STOP_ENTRY,
   input wire epc_pkg::epc_cpu_s CPU_ACC,
   input wire logic [3:0] LOW_CTRL_BITS,
   input wire logic CTRL_BIT7,
   output logic [1:0] ARRAY_STATE,
   output logic ARRAY_PROGRAM_ENABLE,
   output logic FETCH_INVALID
);
   import epc_pkg::*;
   // ----------------------------------------------------------------
   // Bus address phase capture
   // ----------------------------------------------------------------
   logic ph_val_q, ph_val_d, ph_wr_q, ph_wr_d;
   logic [31:0] ph_addr_q, ph_addr_d;
   logic take;
   // A transfer is taken when selected, ready and NONSEQ or SEQ
   assign take = HSEL && HREADY && HTRANS[1];
   // Next address phase
   always_comb begin
      ph_val_d = take;
      ph_wr_d = take ? HWRITE : 1'b0;
      ph_addr_d = take ? HADDR : ph_addr_q;
   end
   // Address phase registers
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ph_val_q <= 1'b0;
         ph_wr_q <= 1'b0;
         ph_addr_q <= 32'h0000_0000;
      end else begin
         ph_val_q <= ph_val_d;
         ph_wr_q <= ph_wr_d;
         ph_addr_q <= ph_addr_d;
      end
   end
   // Data phase decode
   // HSIZE is not decoded: every register takes one whole word
   logic wr_ctrl, wr_arr, rd_arr, in_win;
   assign in_win = (ph_addr_q & EPC_WIN_MASK) == EPC_WIN_BASE;
   assign wr_ctrl = ph_val_q && ph_wr_q && (ph_addr_q == EPC_CTRL_ADDR);
   assign wr_arr = ph_val_q && ph_wr_q && in_win;
   assign rd_arr = ph_val_q && !ph_wr_q && in_win;
   logic [ADDR_W-1:0] arr_addr;
   assign arr_addr = ph_addr_q[ADDR_W+1:2];
   // ----------------------------------------------------------------
   // Control bits and group latch state
   // ----------------------------------------------------------------
   logic lat_q, lat_d, pgm_q, pgm_d, any_q, any_d;
   logic [ADDR_W-EPC_LSB_W-1:0] grp_q, grp_d;
   logic prog_pulse;
   logic [EPC_GRP_BYTES-1:0] slot_vld;
   logic [7:0] slot_dat [EPC_GRP_BYTES];
   logic slot_clr;
   logic [EPC_GRP_BYTES-1:0] slot_wr;
   logic grp_ok;
   // The first latched byte fixes the group; later bytes must match it
   assign grp_ok = !any_q || (arr_addr[ADDR_W-1:EPC_LSB_W] == grp_q);
   // Next control values
   always_comb begin
      lat_d = lat_q;
      pgm_d = pgm_q;
      any_d = any_q;
      grp_d = grp_q;
      prog_pulse = 1'b0;
      slot_wr = '0;
      slot_clr = 1'b0;
      if (wr_ctrl) begin
         lat_d = HWDATA[EPC_LAT_BIT];
         if (HWDATA[EPC_PGM_BIT] && lat_q && any_q) begin
            pgm_d = 1'b1;
         end
      end
      if (lat_q && !pgm_q && wr_arr && grp_ok) begin
         any_d = 1'b1;
         grp_d = arr_addr[ADDR_W-1:EPC_LSB_W];
         slot_wr[arr_addr[EPC_LSB_W-1:0]] = 1'b1;
      end
      if (STOP_ENTRY) begin
         lat_d = 1'b0;
      end
      // Leaving the latch drops program enable and empties the slots
      if (!lat_d) begin
         pgm_d = 1'b0;
         any_d = 1'b0;
         slot_clr = 1'b1;
         prog_pulse = pgm_q; // Burn the group as programming ends
      end
   end
   // Control registers
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         lat_q <= 1'b0;
         pgm_q <= 1'b0;
         any_q <= 1'b0;
         grp_q <= '0;
      end else begin
         lat_q <= lat_d;
         pgm_q <= pgm_d;
         any_q <= any_d;
         grp_q <= grp_d;
      end
   end
   // Sixteen group latch slots
   for (genvar g = 0; g < EPC_GRP_BYTES; g++) begin : g_slot
      epc_slot u_slot (
         .REF_CLK(REF_CLK),
         .SYS_RST(SYS_RST),
         .clr(slot_clr),
         .wr(slot_wr[g]),
         .din(HWDATA[7:0]),
         .vld(slot_vld[g]),
         .dout(slot_dat[g])
      );
   end
   // ----------------------------------------------------------------
   // Array storage: erased to zero, programming ORs ones in
   // ----------------------------------------------------------------
   // Erased at start by the declaration value, so the write process stays its only driver
   logic [7:0] mem [DEPTH] = '{default: EPC_ERASED};
   // A programming pass can only turn zeros into ones
   always_ff @(posedge REF_CLK) begin
      if (prog_pulse) begin
         for (int i = 0; i < EPC_GRP_BYTES; i++) begin
            if (slot_vld[i]) begin
               mem[{grp_q, EPC_LSB_W'(i)}] <= mem[{grp_q, EPC_LSB_W'(i)}] | slot_dat[i];
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // Array read, looked up in the address phase
   // ----------------------------------------------------------------
   // Fetched one cycle early so that HRDATA comes from a flop; a group that
   // commits on the same edge is merged in, so a read right after the
   // closing write already sees the new ones
   logic [ADDR_W-1:0] rq_addr;
   logic [EPC_LSB_W-1:0] rq_idx;
   logic rq_win, rq_hit;
   logic [7:0] rq_byte;
   assign rq_addr = HADDR[ADDR_W+1:2];
   assign rq_idx = rq_addr[EPC_LSB_W-1:0];
   assign rq_win = (HADDR & EPC_WIN_MASK) == EPC_WIN_BASE;
   assign rq_hit = prog_pulse && (rq_addr[ADDR_W-1:EPC_LSB_W] == grp_q) && slot_vld[rq_idx];
   // Stored byte, or a value unrelated to memory while latched
   always_comb begin
      rq_byte = mem[rq_addr];
      if (rq_hit) begin
         rq_byte = rq_byte | slot_dat[rq_idx];
      end
      if (lat_d) begin
         rq_byte = EPC_GARBLE;
      end
   end
   // ----------------------------------------------------------------
   // Read mux and bus response
   // ----------------------------------------------------------------
   // Control value after this edge, so a read right behind a control write sees it
   logic [7:0] ctrl_rd;
   assign ctrl_rd = {CTRL_BIT7, 1'b0, lat_d, pgm_d, LOW_CTRL_BITS};
   logic [31:0] rdat_d, rdat_q;
   // Read data for the next data phase; status has the slot mask at 23:8, the state at 1:0
   always_comb begin
      rdat_d = 32'h0000_0000;
      if (take && !HWRITE) begin
         if (rq_win) begin
            rdat_d = {24'h000000, rq_byte};
         end else if (HADDR == EPC_CTRL_ADDR) begin
            rdat_d = {24'h000000, ctrl_rd};
         end else if (HADDR == EPC_STAT_ADDR) begin
            rdat_d = {8'h00, slot_vld, 6'h00, ARRAY_STATE};
         end else if (HADDR == EPC_GRP_ADDR) begin
            rdat_d = 32'(grp_q);
         end
      end
   end
   // Read data register
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rdat_q <= 32'h0000_0000;
      end else begin
         rdat_q <= rdat_d;
      end
   end
   assign HRDATA = rdat_q;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   // ----------------------------------------------------------------
   // State outputs
   // ----------------------------------------------------------------
   // Both bits clear is read, latch only is ready, both set is programming
   assign ARRAY_STATE = pgm_q ? EPC_PROG : (lat_q ? EPC_READY : EPC_READ);
   assign ARRAY_PROGRAM_ENABLE = pgm_q;
   // Access kinds that neither the array nor the boot ROM can serve while latched
   assign FETCH_INVALID = lat_q && (CPU_ACC.fetch || CPU_ACC.vector || CPU_ACC.boot);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Stop mode entry seen at an edge
   sequence s_stop;
      STOP_ENTRY;
   endsequence
   // Control write that asks for the latch, with no stop to undo it
   sequence s_latch_req;
      wr_ctrl && HWDATA[EPC_LAT_BIT] && !STOP_ENTRY;
   endsequence
   // Control write that asks for programming once a byte is held
   sequence s_arm_req;
      s_latch_req ##0 (HWDATA[EPC_PGM_BIT] && lat_q && any_q);
   endsequence
   // Latch leaving while programming closes the group
   sequence s_close;
      pgm_q && !lat_d;
   endsequence
   // Program enable never stands without the latch
   a_pgm_needs_lat: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      !lat_q |-> !pgm_q) else $error("program enable without latch");
   // Stop entry leaves both bits clear
   a_stop_clears: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      s_stop |=> !lat_q && !pgm_q) else $error("stop did not clear bits");
   // Stop entry also empties the group latches
   a_stop_empty: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      s_stop |=> !any_q && slot_vld == '0) else $error("stop left latched bytes");
   // Program enable rises only from the ready state with a byte held
   a_pgm_set_cond: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      $rose(pgm_q) |-> $past(lat_q) && $past(any_q)) else $error("bad program enable set");
   // A legal arm request is taken
   a_arm_set: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      s_arm_req |=> pgm_q && ARRAY_STATE == EPC_PROG) else $error("arm request ignored");
   // Software cannot clear program enable while the latch stays
   a_pgm_sticky: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      pgm_q && lat_d |=> pgm_q) else $error("program enable cleared by software");
   // Leaving the latch while programming ends the pass and empties the slots
   a_close_burn: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      s_close |=> !pgm_q && !any_q && slot_vld == '0) else $error("group not closed");
   // Array reads while latched never show memory
   a_latch_read: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      rd_arr && lat_q |-> HRDATA[7:0] == EPC_GARBLE) else $error("latched read returned memory");
   // Vector loads are flagged while latched
   a_fetch_bad: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      lat_q && CPU_ACC.vector |-> FETCH_INVALID) else $error("vector not flagged");
   // Boot ROM fetches are flagged while latched
   a_boot_bad: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      lat_q && CPU_ACC.boot |-> FETCH_INVALID) else $error("boot fetch not flagged");
   // No access is flagged in read mode
   a_read_clean: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      !lat_q |-> !FETCH_INVALID) else $error("access flagged in read mode");
   // Array writes in read mode latch nothing
   a_unlatched_wr: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      wr_arr && !lat_q |=> slot_vld == '0) else $error("write latched in read mode");
   // An array write in the ready state lands in a slot
   a_slot_capture: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      lat_q && !pgm_q && wr_arr && grp_ok && !STOP_ENTRY && !wr_ctrl |=> any_q)
      else $error("array write not latched");
   // Array writes during programming change no slot
   a_prog_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      pgm_q && wr_arr && !STOP_ENTRY |=> slot_vld == $past(slot_vld))
      else $error("slot changed while programming");
   // A write outside the latched group is refused
   a_grp_refuse: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      wr_arr && lat_q && !pgm_q && !grp_ok && !STOP_ENTRY |=> grp_q == $past(grp_q) && slot_vld == $past(slot_vld))
      else $error("write outside group accepted");
   // Read mode holds no latched bytes
   a_idle_empty: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      !lat_q |-> !any_q && slot_vld == '0) else $error("bytes held in read mode");
   // A latch request reaches the ready or programming state
   a_latch_set: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      s_latch_req |=> lat_q && ARRAY_STATE != EPC_READ) else $error("latch request ignored");
   // The state code follows the two bits
   a_state_code: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      ARRAY_STATE == {pgm_q, lat_q}) else $error("state code wrong");
endmodule

// *** bench/epc_top_tb_top.sv ***
// Self-checking bench for the EPROM program control block
`timescale 1ns/1ps
module epc_top_tb_top;
   import epc_pkg::*;
   // ----------------------------------------------------------------
   // Signals and instance
   // ----------------------------------------------------------------
   logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, stop, bit7, pgm, finv;
   logic [1:0] htrans, state;
   logic [2:0] hsize;
   logic [3:0] low;
   logic [31:0] haddr, hwdata, hrdata, rd;
   epc_cpu_s cpu;
   int err_total, total_checks;
   // The one slave's ready is the bus ready
   assign hready = hreadyout;
   epc_top i_dut (.REF_CLK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata),
      .STOP_ENTRY(stop), .CPU_ACC(cpu), .LOW_CTRL_BITS(low), .CTRL_BIT7(bit7), .ARRAY_STATE(state),
      .ARRAY_PROGRAM_ENABLE(pgm), .FETCH_INVALID(finv));
   // Clock generator, 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   // Wait for ready at rising edges; the value standing before the edge is taken
   task automatic wait_rdy();
      do begin
         @(posedge clk);
      end while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // One single word transfer, address phase then data phase
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'h2;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
   endtask
   task automatic rdchk(input logic [31:0] a, input logic [7:0] exp, input string msg);
      ahb(1'b0, a, 32'h0);
      check({24'h0, rd[7:0]}, {24'h0, exp}, msg);
      check({31'h0, hresp}, 32'h0, "okay response");
   endtask
   // Byte address of array index n
   function automatic logic [31:0] arr(input int n);
      return EPC_WIN_BASE + 32'(4 * n);
   endfunction
   // State and program enable after the last edge has landed
   task automatic st(input logic [1:0] s, input logic p, input string msg);
      @(negedge clk);
      check({29'h0, state, pgm}, {29'h0, s, p}, msg);
      @(posedge clk);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      st(2'h0, 1'b0, "state after reset");
      rdchk(EPC_CTRL_ADDR, 8'h8A, "ctrl after reset");
      rdchk(arr(5), EPC_ERASED, "erased byte");
   endtask
   task automatic t_group();
      ahb(1'b1, EPC_CTRL_ADDR, 32'h10);
      st(2'h0, 1'b0, "program without latch");
      ahb(1'b1, EPC_CTRL_ADDR, 32'h6F);
      rdchk(EPC_CTRL_ADDR, 8'hAA, "ctrl readback");
      ahb(1'b1, EPC_CTRL_ADDR, 32'h30);
      st(2'h1, 1'b0, "program before any byte");
      rdchk(arr(3), EPC_GARBLE, "latched array read");
      for (int i = 0; i < 3; i++) begin
         cpu <= epc_cpu_s'(3'(1 << i));
         @(negedge clk);
         check({31'h0, finv}, 32'h1, "access while latched");
         @(posedge clk);
      end
      cpu <= epc_cpu_s'(3'h0);
      ahb(1'b1, arr(18), 32'h05);
      ahb(1'b1, arr(31), 32'h81);
      ahb(1'b1, arr(34), 32'h77);
      ahb(1'b0, EPC_STAT_ADDR, 32'h0);
      check(rd, 32'h0080_0401, "slot mask and ready state");
      ahb(1'b0, EPC_GRP_ADDR, 32'h0);
      check(rd, 32'h0000_0001, "latched group");
      ahb(1'b1, EPC_CTRL_ADDR, 32'h30);
      st(2'h3, 1'b1, "programming state");
      ahb(1'b1, EPC_CTRL_ADDR, 32'h20);
      st(2'h3, 1'b1, "zero to program bit");
      ahb(1'b1, EPC_CTRL_ADDR, 32'h00);
      st(2'h0, 1'b0, "latch cleared");
      rdchk(arr(18), 8'h05, "group byte low");
      rdchk(arr(31), 8'h81, "group byte high");
      rdchk(arr(34), 8'h00, "other group byte");
      ahb(1'b1, 32'h40, 32'hFF);
      ahb(1'b0, 32'h40, 32'h0);
      check(rd, 32'h0, "unmapped read");
   endtask
   task automatic t_accum();
      ahb(1'b1, EPC_CTRL_ADDR, 32'h20);
      ahb(1'b1, arr(18), 32'h50);
      ahb(1'b1, EPC_CTRL_ADDR, 32'h30);
      ahb(1'b1, EPC_CTRL_ADDR, 32'h00);
      rdchk(arr(18), 8'h55, "accumulated ones");
      cpu <= epc_cpu_s'(3'h7);
      @(negedge clk);
      check({31'h0, finv}, 32'h0, "fetch in read mode");
      @(posedge clk);
      cpu <= epc_cpu_s'(3'h0);
   endtask
   task automatic t_stop();
      ahb(1'b1, EPC_CTRL_ADDR, 32'h20);
      ahb(1'b1, arr(40), 32'h0C);
      ahb(1'b1, EPC_CTRL_ADDR, 32'h30);
      stop <= 1'b1;
      @(posedge clk);
      stop <= 1'b0;
      st(2'h0, 1'b0, "stop entry");
      ahb(1'b1, EPC_CTRL_ADDR, 32'h20);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      st(2'h0, 1'b0, "reset in mid run");
   endtask
   // ----------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Cut a hang short
   initial begin
      #(25 * 5000);
      err_total++;
      conclude();
   end
   // Reset, then the scenarios
   initial begin
      err_total = 0;
      total_checks = 0;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      stop = 1'b0;
      cpu = epc_cpu_s'(3'h0);
      low = 4'hA;
      bit7 = 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_group();
      t_accum();
      t_stop();
      conclude();
   end
endmodule
